// ==== core/eid_pkg.sv ====
// eid_pkg: constants, config carriers and helpers for the edge/debounce
// block; assumes one 125 MHz clock and no register bus.
package eid_pkg;
  localparam int          NPIN      = 8;    // external irq pins
  localparam int          NALL      = 9;    // pins plus the nmi pin
  localparam int          CNT_W     = 4;    // transition counter width
  localparam int          PSC_W     = 3;    // prescaler select width
  localparam int          TCK_W     = 8;    // tick divider width
  localparam logic [1:0]  SLOW_LAST = 2'h3; // slow controller clock 1/4
  localparam logic [3:0]  THR_LO    = 4'h4; // short transition count
  localparam logic [3:0]  THR_HI    = 4'h8; // long transition count
  localparam logic        LVL_RST   = 1'h0; // valid level after reset

  // edge sense encodings of a pin
  typedef enum logic [2:0] {
    SNS_NONE = 3'h0,
    SNS_RISE = 3'h1,
    SNS_FALL = 3'h2,
    SNS_BOTH = 3'h3,
    SNS_HIGH = 3'h4,
    SNS_LOW  = 3'h5
  } eid_sense_t;

  // per-pin configuration
  typedef struct packed {
    eid_sense_t sense;   // edge_sense_select
    logic       deb_req; // debouncer requested
    logic       filt_req;// majority_filter_enable
  } eid_pin_cfg_t;

  // debounce prescaler configuration
  typedef struct packed {
    logic             tick_on;   // bounce_eval_on_tick
    logic             count_sel; // debounce_count_select
    logic [PSC_W-1:0] presc;     // tick period select
  } eid_dpr_cfg_t;

  // does the pin event match the configured sense
  function automatic logic sense_hit(eid_sense_t s, logic edg, logic lvl);
    unique case (s)
      SNS_RISE: sense_hit = edg & lvl;
      SNS_FALL: sense_hit = edg & ~lvl;
      SNS_BOTH: sense_hit = edg;
      SNS_HIGH: sense_hit = lvl;
      SNS_LOW:  sense_hit = ~lvl;
      default:  sense_hit = 1'b0;
    endcase
  endfunction

  // sense settings that allow the debouncer
  function automatic logic is_edge_sense(eid_sense_t s);
    is_edge_sense = (s == SNS_RISE) | (s == SNS_FALL) | (s == SNS_BOTH);
  endfunction

  // transition count threshold
  function automatic logic [3:0] thr_of(logic asy, logic sel);
    thr_of = (!asy && sel) ? THR_HI : THR_LO;
  endfunction

  // majority of three samples
  function automatic logic maj3(logic [2:0] h);
    maj3 = (h[0] & h[1]) | (h[1] & h[2]) | (h[0] & h[2]);
  endfunction
endpackage

// ==== core/eid_tick_gen.sv ====
// eid_tick_gen: divides the controller clock enable into the slow
// debounce tick; assumes step_i is a one-cycle enable on clk_i.
`timescale 1ns/1ns
module eid_tick_gen (
  input  wire logic                      clk_i,
  input  wire logic                      sys_rst_i,
  input  wire logic                      step_i,
  input  wire logic [eid_pkg::PSC_W-1:0] presc_i,
  output logic                           tick_o
);
  logic [eid_pkg::TCK_W-1:0] cnt_r;   // steps since last tick
  logic [eid_pkg::TCK_W-1:0] cnt_nxt;
  logic [eid_pkg::TCK_W-1:0] lim;     // last count of a period
  logic                      tick_r;
  logic                      tick_nxt;

  // period of 2^(presc+1) controller clocks
  always_comb begin
    lim      = eid_pkg::TCK_W'((9'h002 << presc_i) - 9'h001);
    cnt_nxt  = cnt_r;
    tick_nxt = 1'b0;
    if (step_i) begin
      if (cnt_r >= lim) begin // also catches a shrunk period
        cnt_nxt  = '0;
        tick_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 1'b1;
      end
    end
  end

  // register only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      cnt_r  <= '0;
      tick_r <= 1'b0;
    end else begin
      cnt_r  <= cnt_nxt;
      tick_r <= tick_nxt;
    end
  end

  assign tick_o = tick_r;
endmodule // eid_tick_gen

// ==== core/eid_debounce.sv ====
// eid_debounce: one pin's debouncer with valid level and counter;
// assumes pin_i already synchronised and strobes on clk_i.
`timescale 1ns/1ns
module eid_debounce (
  input  wire logic clk_i,
  input  wire logic sys_rst_i,
  input  wire logic en_i,        // debouncing active on this pin
  input  wire logic smp_i,       // sample strobe: controller clock, or every clock if async
  input  wire logic tick_i,      // slow debounce tick
  input  wire logic pin_i,       // synchronised pin
  input  wire logic async_i,     // async_mode_select of the pin
  input  wire logic count_sel_i, // debounce_count_select
  input  wire logic tick_on_i,   // bounce_eval_on_tick
  output logic      level_o,     // valid level
  output logic      accept_o     // pulse with each threshold flip of the level
);
  logic                      smp_r, smp_nxt;     // latest sample
  logic                      val_r, val_nxt;     // valid level
  logic [eid_pkg::CNT_W-1:0] cnt_r, cnt_nxt;     // transitions
  logic                      acc_r, acc_nxt;
  logic                      trans, bounce;
  logic [3:0]                thr;

  // sample, compare, count, flip
  always_comb begin
    thr     = eid_pkg::thr_of(async_i, count_sel_i); // RULE14
    smp_nxt = smp_i ? pin_i : smp_r; // RULE11
    trans   = tick_i & (smp_r != val_r); // RULE11
    bounce  = (tick_on_i ? tick_i : smp_i) & (smp_r == val_r); // RULE12
    cnt_nxt = cnt_r;
    val_nxt = val_r;
    acc_nxt = 1'b0;
    if (!en_i) begin
      // idle debouncer just mirrors the sample
      cnt_nxt = '0;
      val_nxt = smp_r;
    end else if (bounce) begin
      cnt_nxt = '0; // RULE13
    end else if (trans) begin
      if (cnt_r + 4'h1 >= thr) begin
        val_nxt = ~val_r; // RULE16
        cnt_nxt = '0; // RULE16
        acc_nxt = 1'b1;
      end else begin
        cnt_nxt = cnt_r + 4'h1; // RULE13
      end
    end
  end

  // register only
  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      smp_r <= eid_pkg::LVL_RST;
      val_r <= eid_pkg::LVL_RST;
      cnt_r <= '0;
      acc_r <= 1'b0;
    end else begin
      smp_r <= smp_nxt;
      val_r <= val_nxt;
      cnt_r <= cnt_nxt;
      acc_r <= acc_nxt;
    end
  end

  assign level_o  = val_r;
  assign accept_o = acc_r;

  // a bounce clears the counter
  property p_bounce_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
      (en_i && bounce) |=> (cnt_r == 4'h0);
  endproperty
  a_bounce_clr: assert property (p_bounce_clr) // RULE13
    else $error("counter not cleared by bounce");

  // a flip only after the threshold count
  property p_accept_thr;
    @(posedge clk_i) disable iff (sys_rst_i)
      acc_r |-> ($past(cnt_r) + 4'h1 == $past(thr));
  endproperty
  a_accept_thr: assert property (p_accept_thr) // RULE14
    else $error("level accepted at wrong count");

  // accept inverts the level and clears the counter
  property p_flip;
    @(posedge clk_i) disable iff (sys_rst_i)
      (en_i && !bounce && trans && cnt_r + 4'h1 >= thr)
        |=> (acc_r && val_r != $past(val_r) && cnt_r == 4'h0);
  endproperty
  a_flip: assert property (p_flip) // RULE16
    else $error("level did not flip at threshold");

  c_accept: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    acc_r);
endmodule // eid_debounce

// ==== core/eid_edge_debounce.sv ====
// eid_edge_debounce: edge detection and sticky flags for the external irq
// pins and the nmi pin; optional debouncing for the external irq pins only.
// assumes asynchronous pins, one 125 MHz clock, config as plain ports.
`timescale 1ns/1ns

// Notes on behaviour
// RULE1: async select 0 sync, 1 async
// RULE2: sync mode flags when sample differs previous
// RULE3: any sync pin keeps clock requested
// RULE4: async pins flag directly, no clock request
// RULE5: detection keeps running in idle, standby
// RULE6: per-pin debouncer follows pin async select
// RULE7: debouncer uses controller clock, prescaled tick
// RULE8: debounce only with rise, fall, both
// RULE9: debounce and majority filter exclusive
// RULE10: per-pin valid level tracks debounced pin
// RULE11: tick compares sample with level, counts
// RULE12: bounce checked each clock or tick
// RULE13: transition increments counter, bounce clears it
// RULE14: threshold four, or eight when selected; async pins always use four
// RULE15: debounced levels readable as status
// RULE16: threshold flips level, clears, flags matching
// RULE17: flags stay set until software clears
module eid_edge_debounce (
  input  wire logic                           clk_i,
  input  wire logic                           sys_rst_i,
  input  wire logic [eid_pkg::NPIN-1:0]       ext_irq_pin_i,
  input  wire logic                           nmi_pin_i,
  input  wire logic [eid_pkg::NPIN-1:0]       async_mode_select_i,
  input  wire logic                           nmi_async_i,
  input  wire logic                           clock_source_select_i,
  input  wire eid_pkg::eid_pin_cfg_t [eid_pkg::NPIN-1:0] pin_cfg_i,
  input  wire eid_pkg::eid_sense_t            nmi_sense_i,
  input  wire eid_pkg::eid_dpr_cfg_t          debounce_prescaler_cfg_i,
  input  wire logic [eid_pkg::NPIN-1:0]       irq_flag_clr_i,
  input  wire logic                           nmi_flag_clr_i,
  output logic [eid_pkg::NPIN-1:0]            irq_flag_register_o,
  output logic                                nonmaskable_event_flag_o,
  output logic [eid_pkg::NPIN-1:0]            debounced_level_o,
  output logic                                clk_req_o
);
  localparam int N = eid_pkg::NPIN;
  localparam int A = eid_pkg::NALL;

  // synchroniser stages, nmi at the top index
  logic [A-1:0]       sy1_r, sy1_nxt;   // first stage, read by sy2 only
  logic [A-1:0]       sy2_r, sy2_nxt;
  // controller clock divider
  logic [1:0]         div_r, div_nxt;
  logic               ctl_en;           // controller clock strobe
  // config as actually applied
  logic [N-1:0]       deb_eff;          // debouncer in use
  logic [N-1:0]       filt_eff;         // majority filter in use
  logic [A-1:0]       asy_all;          // async select incl. nmi
  // sampling
  logic [2:0]         hist_r [A];       // newest sample in bit 0
  logic [2:0]         hist_nxt [A];
  logic [A-1:0]       upd;              // sample strobe per pin
  logic [A-1:0]       vcur;             // current pin value
  logic [A-1:0]       last_r, last_nxt; // value one cycle back
  logic [A-1:0]       edg;              // value changed
  // debouncer results
  logic               tick;
  logic [N-1:0]       deb_lvl;
  logic [N-1:0]       deb_acc;
  // flags and outputs
  logic [N-1:0]       flag_r, flag_nxt;
  logic [N-1:0]       set_irq;
  logic               nmi_r, nmi_nxt;
  logic               set_nmi;
  logic               req_r, req_nxt;
  logic [N-1:0]       lvl_r, lvl_nxt;

  // two-flop synchroniser for all pins
  always_comb begin
    sy1_nxt = {nmi_pin_i, ext_irq_pin_i};
    sy2_nxt = sy1_r;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      sy1_r <= '0;
      sy2_r <= '0;
    end else begin
      sy1_r <= sy1_nxt;
      sy2_r <= sy2_nxt;
    end
  end

  // controller clock: full rate or the slow divided source
  always_comb begin
    div_nxt = (div_r == eid_pkg::SLOW_LAST) ? 2'h0 : div_r + 2'h1;
    ctl_en  = clock_source_select_i ? (div_r == eid_pkg::SLOW_LAST)
                                    : 1'b1;
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      div_r <= '0;
    end else begin
      div_r <= div_nxt;
    end
  end

  // legal combinations of debouncer and filter
  always_comb begin
    asy_all = {nmi_async_i, async_mode_select_i};
    for (int i = 0; i < N; i++) begin
      deb_eff[i]  = pin_cfg_i[i].deb_req &
                    eid_pkg::is_edge_sense(pin_cfg_i[i].sense); // RULE8
      filt_eff[i] = pin_cfg_i[i].filt_req & ~deb_eff[i]; // RULE9
    end
  end

  // sample on the controller clock in sync mode, at once in async
  always_comb begin
    for (int i = 0; i < A; i++) begin
      // async pins bypass the controller clock strobe
      upd[i]      = asy_all[i] | ctl_en; // RULE1 RULE4
      hist_nxt[i] = upd[i] ? {hist_r[i][1:0], sy2_r[i]}
                           : hist_r[i]; // RULE2
      if (i < N && filt_eff[i % N]) begin
        vcur[i] = eid_pkg::maj3(hist_r[i]);
      end else begin
        vcur[i] = hist_r[i][0];
      end
    end
    last_nxt = vcur;
    edg      = vcur ^ last_r; // RULE2
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      for (int i = 0; i < A; i++) begin
        hist_r[i] <= '0;
      end
      last_r <= '0;
    end else begin
      for (int i = 0; i < A; i++) begin
        hist_r[i] <= hist_nxt[i];
      end
      last_r <= last_nxt;
    end
  end

  // slow tick shared by all debouncers
  eid_tick_gen u_tick (
    .clk_i     (clk_i),
    .sys_rst_i (sys_rst_i),
    .step_i    (ctl_en), // RULE7
    .presc_i   (debounce_prescaler_cfg_i.presc),
    .tick_o    (tick)
  );

  // one debouncer per external pin; nmi is never debounced
  for (genvar g = 0; g < N; g++) begin : g_deb
    eid_debounce u_deb (
      .clk_i       (clk_i),
      .sys_rst_i   (sys_rst_i),
      .en_i        (deb_eff[g]),
      .smp_i       (upd[g]), // RULE6
      .tick_i      (tick),
      .pin_i       (sy2_r[g]),
      .async_i     (asy_all[g]), // RULE6
      .count_sel_i (debounce_prescaler_cfg_i.count_sel),
      .tick_on_i   (debounce_prescaler_cfg_i.tick_on),
      .level_o     (deb_lvl[g]), // RULE10
      .accept_o    (deb_acc[g])
    );
  end

  // sticky flags; nothing here is gated by sleep state
  always_comb begin
    for (int i = 0; i < N; i++) begin
      if (deb_eff[i]) begin
        // accept pulse comes with the new level already in place
        set_irq[i] = deb_acc[i] &
          eid_pkg::sense_hit(pin_cfg_i[i].sense, 1'b1, deb_lvl[i]); // RULE16
      end else begin
        set_irq[i] = eid_pkg::sense_hit(pin_cfg_i[i].sense, edg[i],
                                        vcur[i]); // RULE2 RULE4 RULE5
      end
    end
    set_nmi  = eid_pkg::sense_hit(nmi_sense_i, edg[A-1], vcur[A-1]);
    // set beats a clear in the same cycle
    flag_nxt = set_irq | (flag_r & ~irq_flag_clr_i); // RULE17
    nmi_nxt  = set_nmi | (nmi_r & ~nmi_flag_clr_i); // RULE17
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      flag_r <= '0;
      nmi_r  <= 1'b0;
    end else begin
      flag_r <= flag_nxt;
      nmi_r  <= nmi_nxt;
    end
  end

  // clock request and readable debounced levels
  always_comb begin
    req_nxt = |(~asy_all); // RULE3 RULE4
    lvl_nxt = deb_lvl; // RULE15
  end

  always_ff @(posedge clk_i or posedge sys_rst_i) begin
    if (sys_rst_i) begin
      req_r <= 1'b0;
      lvl_r <= '0;
    end else begin
      req_r <= req_nxt;
      lvl_r <= lvl_nxt;
    end
  end

  assign irq_flag_register_o      = flag_r;
  assign nonmaskable_event_flag_o = nmi_r;
  assign debounced_level_o        = lvl_r;
  assign clk_req_o                = req_r;

  // a sync pin keeps the clock requested
  property p_clk_req;
    @(posedge clk_i) disable iff (sys_rst_i)
      (~asy_all != '0) |=> clk_req_o;
  endproperty
  a_clk_req: assert property (p_clk_req) // RULE3
    else $error("clock not requested for sync pin");

  // all async: no request for the clock
  property p_no_req;
    @(posedge clk_i) disable iff (sys_rst_i)
      (&asy_all) |=> !clk_req_o;
  endproperty
  a_no_req: assert property (p_no_req) // RULE4
    else $error("clock requested with all pins async");

  // a plain both-edge pin flags on a sample change
  property p_edge_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
      (!deb_eff[3] && pin_cfg_i[3].sense == eid_pkg::SNS_BOTH && edg[3])
        |=> irq_flag_register_o[3];
  endproperty
  a_edge_flag: assert property (p_edge_flag) // RULE2
    else $error("edge did not set its flag");

  // a level-sensed pin never sees a debounced accept
  property p_deb_sense;
    @(posedge clk_i) disable iff (sys_rst_i)
      !eid_pkg::is_edge_sense(pin_cfg_i[0].sense) |=> !deb_acc[0];
  endproperty
  a_deb_sense: assert property (p_deb_sense) // RULE8
    else $error("debounce active with level sense");

  // with the debouncer on, the filter stays out of the sample path
  property p_excl;
    @(posedge clk_i) disable iff (sys_rst_i)
      deb_eff[0] |-> (vcur[0] == hist_r[0][0]);
  endproperty
  a_excl: assert property (p_excl) // RULE9
    else $error("filter and debounce both on");

  // flags hold until cleared
  property p_sticky;
    @(posedge clk_i) disable iff (sys_rst_i)
      (flag_r[0] && !irq_flag_clr_i[0]) ##1 !irq_flag_clr_i[0]
        |-> flag_r[0] [*2];
  endproperty
  a_sticky: assert property (p_sticky) // RULE17
    else $error("flag dropped without a clear");

  // the status shows the level one cycle on
  property p_lvl;
    @(posedge clk_i) disable iff (sys_rst_i)
      deb_acc[0] |=> (debounced_level_o[0] == $past(deb_lvl[0]))
                     && (debounced_level_o[0] != $past(lvl_r[0]));
  endproperty
  a_lvl: assert property (p_lvl) // RULE15
    else $error("debounced level not shown");

  // nmi edge sets its flag on the next clock
  property p_nmi_flag;
    @(posedge clk_i) disable iff (sys_rst_i)
      (nmi_sense_i == eid_pkg::SNS_BOTH && edg[A-1])
        |=> nonmaskable_event_flag_o;
  endproperty
  a_nmi_flag: assert property (p_nmi_flag) // RULE2
    else $error("nmi edge did not set its flag");

  // a sync pin samples only on the slow strobe
  property p_slow_hold;
    @(posedge clk_i) disable iff (sys_rst_i)
      (clock_source_select_i && !asy_all[A-1] && !ctl_en)
        |=> $stable(hist_r[A-1]);
  endproperty
  a_slow_hold: assert property (p_slow_hold) // RULE2
    else $error("sample moved between slow strobes");

  // a clear with no new event drops the flag
  property p_clr;
    @(posedge clk_i) disable iff (sys_rst_i)
      (irq_flag_clr_i[0] && !set_irq[0]) |=> !irq_flag_register_o[0];
  endproperty
  a_clr: assert property (p_clr) // RULE17
    else $error("flag survived a clear");

  // an async pin samples every clock, whatever the clock source
  property p_async_fast;
    @(posedge clk_i) disable iff (sys_rst_i)
      asy_all[0] |=> (hist_r[0][0] == $past(sy2_r[0]));
  endproperty
  a_async_fast: assert property (p_async_fast) // RULE4
    else $error("async pin not sampled at once");

  c_async_edge: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    asy_all[0] && set_irq[0]);
  c_nmi: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    set_nmi && !nmi_r);
  c_set_clr: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    set_irq[0] && irq_flag_clr_i[0]);
  c_filter: cover property (@(posedge clk_i) disable iff (sys_rst_i)
    filt_eff[6] && edg[6]);
endmodule // eid_edge_debounce

// ==== testbench/eid_pin_model.sv ====
// eid_pin_model: stands in for the boards that drive the external pins.
// assumes commands change just after a rising edge of clk_i.
`timescale 1ns/1ns
module eid_pin_model (
  input  wire logic                     clk_i,
  input  wire logic [eid_pkg::NPIN-1:0] tgt_i,     // commanded pin levels
  input  wire logic                     nmi_tgt_i, // commanded nmi level
  input  wire logic                     chat_i,    // chatter on pin 0
  output logic      [eid_pkg::NPIN-1:0] pin_o,     // external pins
  output logic                          nmi_o      // nmi pin
);
  logic [2:0] ph_r = 3'h0; // chatter phase, six steps

  // pins move only after an edge, as a real driver would
  always_ff @(posedge clk_i) begin
    ph_r  <= (ph_r == 3'h5) ? 3'h0 : ph_r + 3'h1;
    pin_o <= tgt_i;
    nmi_o <= nmi_tgt_i;
    // two low cycles in six, so every glitch spans one slow tick
    if (chat_i && ph_r >= 3'h4) begin
      pin_o[0] <= 1'b0;
    end
  end
endmodule // eid_pin_model

// ==== testbench/eid_edge_debounce_tb.sv ====
// eid_edge_debounce_tb: self-checking bench for the edge/debounce block.
// assumes the pin model drives the pins and the bench all config ports.
`timescale 1ns/1ns
module eid_edge_debounce_tb;
  localparam int LIMIT = 3000; // cycle ceiling for the whole run

  logic                                   clk_i      = 1'b0;
  logic                                   sys_rst_i  = 1'b1;
  logic [7:0]                             tgt        = 8'h00;
  logic                                   nmi_tgt    = 1'b0;
  logic                                   chat       = 1'b0;
  logic [7:0]                             async_mode = 8'h00;
  logic                                   nmi_async  = 1'b0;
  logic                                   csel       = 1'b0;
  eid_pkg::eid_pin_cfg_t [eid_pkg::NPIN-1:0] pin_cfg = '0;
  eid_pkg::eid_sense_t                    nmi_sense  = eid_pkg::SNS_NONE;
  eid_pkg::eid_dpr_cfg_t                  dpr        = '0;
  logic [7:0]                             clr        = 8'h00;
  logic                                   nmi_clr    = 1'b0;
  logic [7:0]                             pins;      // pins from model
  logic                                   nmi_pin;   // nmi from model
  logic [7:0]                             flag_o;
  logic                                   nmi_flag_o;
  logic [7:0]                             lvl_o;
  logic                                   clk_req_o;
  int                                     fail_count = 0;
  int                                     checked    = 0;
  int                                     cyc_cnt    = 0;

  // free-running clock, 8 ns
  initial begin
    forever #4 clk_i = ~clk_i;
  end

  eid_pin_model pm (
    .clk_i(clk_i), .tgt_i(tgt), .nmi_tgt_i(nmi_tgt), .chat_i(chat),
    .pin_o(pins), .nmi_o(nmi_pin));

  eid_edge_debounce dut (
    .clk_i(clk_i), .sys_rst_i(sys_rst_i), .ext_irq_pin_i(pins),
    .nmi_pin_i(nmi_pin), .async_mode_select_i(async_mode),
    .nmi_async_i(nmi_async), .clock_source_select_i(csel),
    .pin_cfg_i(pin_cfg), .nmi_sense_i(nmi_sense),
    .debounce_prescaler_cfg_i(dpr), .irq_flag_clr_i(clr),
    .nmi_flag_clr_i(nmi_clr), .irq_flag_register_o(flag_o),
    .nonmaskable_event_flag_o(nmi_flag_o), .debounced_level_o(lvl_o),
    .clk_req_o(clk_req_o));

  task automatic complete_run();
    if (fail_count == 0 && checked > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // hang guard: a run past the ceiling counts as a mismatch
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == LIMIT) begin
      fail_count++;
      complete_run();
    end
  end

  // step past the edge so compares see what it launched
  task automatic cyc(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask

  // vector compare; callers arrive after the edge has settled
  task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // single bit compare
  task automatic chk1(input logic got, input logic exp);
    checked++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // one-cycle clear of every flag
  task automatic clr_pulse();
    @(posedge clk_i);
    clr <= 8'hff;
    nmi_clr <= 1'b1;
    @(posedge clk_i);
    clr <= 8'h00;
    nmi_clr <= 1'b0;
  endtask

  task automatic t_reset();
    cyc(2);
    chk8(flag_o, 8'h00);
    chk8(lvl_o, 8'h00);
    chk1(clk_req_o, 1'b1);
  endtask

  // pins 0..5 get every sense code; 6 and 7 stay off
  task automatic t_sense();
    for (int k = 0; k < 6; k++) begin
      @(posedge clk_i);
      pin_cfg[k] <= '{sense: eid_pkg::eid_sense_t'(k[2:0]),
                      deb_req: 1'b0, filt_req: 1'b0};
    end
    cyc(8);
    clr_pulse();
    @(posedge clk_i);
    tgt <= 8'hff;
    cyc(8);
    chk8(flag_o, 8'h3a);
    clr_pulse();
    cyc(3);
    chk8(flag_o, 8'h10);
    @(posedge clk_i);
    tgt <= 8'h00;
    cyc(8);
    chk8(flag_o, 8'h3c);
  endtask

  // nmi edge with the slow controller clock
  task automatic t_nmi_slow();
    @(posedge clk_i);
    csel <= 1'b1;
    nmi_sense <= eid_pkg::SNS_BOTH;
    nmi_tgt <= 1'b1;
    cyc(12);
    chk1(nmi_flag_o, 1'b1);
    clr_pulse();
    cyc(3);
    chk1(nmi_flag_o, 1'b0);
    @(posedge clk_i);
    csel <= 1'b0;
  endtask

  // all pins async drop the clock request; one sync pin restores it
  task automatic t_async();
    @(posedge clk_i);
    async_mode <= 8'hff;
    nmi_async <= 1'b1;
    cyc(3);
    chk1(clk_req_o, 1'b0);
    clr_pulse();
    @(posedge clk_i);
    tgt <= 8'h02;
    cyc(6);
    chk8(flag_o & 8'h02, 8'h02);
    @(posedge clk_i);
    async_mode <= 8'hfe;
    tgt <= 8'h00;
    cyc(3);
    chk1(clk_req_o, 1'b1);
  endtask

  // steady rise on pin 0: level flips only after the threshold
  task automatic deb_run(input logic asy, input logic sel, input int t0,
                         input int t1);
    @(posedge clk_i);
    async_mode <= {7'h00, asy};
    dpr <= '{tick_on: 1'b0, count_sel: sel, presc: 3'h0};
    tgt <= 8'h00;
    cyc(20);
    clr_pulse();
    @(posedge clk_i);
    tgt <= 8'h01;
    cyc(t0);
    chk1(lvl_o[0], 1'b0);
    cyc(t1 - t0);
    chk1(lvl_o[0], 1'b1);
    chk1(flag_o[0], 1'b1);
    @(posedge clk_i);
    tgt <= 8'h00;
    cyc(40);
    chk1(lvl_o[0], 1'b0);
  endtask

  // chatter never lets the counter reach four, either bounce setting
  task automatic t_bounce();
    for (int t = 0; t < 2; t++) begin
      @(posedge clk_i);
      dpr <= '{tick_on: t[0], count_sel: 1'b0, presc: 3'h0};
      async_mode <= 8'h00;
      cyc(20);
      @(posedge clk_i);
      tgt <= 8'h01;
      chat <= 1'b1;
      cyc(60);
      chk1(lvl_o[0], 1'b0);
      @(posedge clk_i);
      chat <= 1'b0;
      tgt <= 8'h00;
    end
  endtask

  // level sense refuses the debouncer: level follows the pin at once
  task automatic t_level_sense();
    @(posedge clk_i);
    pin_cfg[0] <= '{sense: eid_pkg::SNS_HIGH, deb_req: 1'b1, filt_req: 1'b0};
    cyc(20);
    @(posedge clk_i);
    tgt <= 8'h01;
    cyc(7);
    chk1(lvl_o[0], 1'b1);
    chk1(flag_o[0], 1'b1);
  endtask

  // majority filter drops a one-cycle pulse; the plain pin flags it
  task automatic t_filter();
    @(posedge clk_i);
    pin_cfg[6] <= '{sense: eid_pkg::SNS_BOTH, deb_req: 1'b0, filt_req: 1'b1};
    pin_cfg[7] <= '{sense: eid_pkg::SNS_BOTH, deb_req: 1'b0, filt_req: 1'b0};
    cyc(8);
    clr_pulse();
    @(posedge clk_i);
    tgt[7:6] <= 2'h3;
    @(posedge clk_i);
    tgt[7:6] <= 2'h0;
    cyc(8);
    chk8(flag_o & 8'hc0, 8'h80);
    clr_pulse();
    @(posedge clk_i);
    tgt[7:6] <= 2'h3;
    cyc(8);
    chk8(flag_o & 8'hc0, 8'hc0);
  endtask

  // main sequence
  initial begin
    repeat (4) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    t_reset();
    t_sense();
    t_nmi_slow();
    t_async();
    @(posedge clk_i);
    pin_cfg <= '0;
    @(posedge clk_i);
    pin_cfg[0] <= '{sense: eid_pkg::SNS_RISE, deb_req: 1'b1, filt_req: 1'b1};
    deb_run(1'b0, 1'b0, 8, 16);
    deb_run(1'b0, 1'b1, 16, 30);
    deb_run(1'b1, 1'b1, 8, 16);
    t_bounce();
    t_level_sense();
    t_filter();
    complete_run();
  end
endmodule // eid_edge_debounce_tb
